// ==== design/caprf_map.svh ====
// register offsets, field positions, reset values, write masks and vector bases
`ifndef CAPRF_MAP_SVH
`define CAPRF_MAP_SVH
`define CAPRF_STACK_POINTER 8'h81
`define CAPRF_POINTER0_LOW 8'h82
`define CAPRF_POINTER0_HIGH 8'h83
`define CAPRF_POINTER1_LOW 8'h84
`define CAPRF_POINTER1_HIGH 8'h85
`define CAPRF_POINTER_SELECT 8'h86
`define CAPRF_FLASH_WAIT_STATES 8'h92
`define CAPRF_POINTER0_TOP 8'h93
`define CAPRF_POINTER1_TOP 8'h95
`define CAPRF_STACK_POINTER_UPPER 8'h9b
`define CAPRF_ADDRESSING_CONTROL 8'h9d
`define CAPRF_INTERRUPT_PROGRESS_STATUS 8'hc5
`define CAPRF_XDATA_RELOCATION 8'hc6
`define CAPRF_PROGRAM_STATUS_WORD 8'hd0
`define CAPRF_INDIRECT_HIGH_BYTE 8'hda
`define CAPRF_INDIRECT_UPPER_BYTE 8'hea
`define CAPRF_SECONDARY_OPERAND 8'hf0
`define CAPRF_WAIT_RESET 8'h07
`define CAPRF_WAIT_MASK 8'h0f
`define CAPRF_ADDRESSING_CONTROL_MASK 8'h2b
`define CAPRF_SELECT_MASK 8'he1
`define CAPRF_STATUS_MASK 8'h60
`define CAPRF_BIT_VECTOR_RELOCATE 5
`define CAPRF_BIT_ALT_HIGH_BYTE_ENABLE 3
`define CAPRF_BIT_STACK_EXTENDED_FLAG 2
`define CAPRF_BIT_ADDRESS_MODE_HI 1
`define CAPRF_BIT_POINTER1_DIRECTION 7
`define CAPRF_BIT_POINTER0_DIRECTION 6
`define CAPRF_BIT_TOGGLE_SELECT 5
`define CAPRF_BIT_SELECT 0
`define CAPRF_BIT_HIGH_PRIO 6
`define CAPRF_BIT_LOW_PRIO 5
`define CAPRF_VECTOR_BASE_RELOCATED 20'h0_b000
`define CAPRF_VECTOR_BASE_NORMAL 20'h0_0000
`endif

// ==== design/caprf_pkg.sv ====
// types shared by the addressing register block
package caprf_pkg;
	typedef enum logic [1:0] {CAPRF_FETCH_IDLE, CAPRF_FETCH_WAIT} caprf_fetch_e;
	typedef logic [7:0] caprf_byte_t;
endpackage : caprf_pkg

// ==== design/caprf_wait_timer.sv ====
// program fetch wait-state sequencer
`timescale 1ns/1ps
`include "caprf_map.svh"
module caprf_wait_timer
	import caprf_pkg::*;
#(
	parameter int WAIT_WIDTH = 4
) (
	input wire logic core_clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic fetchReq, // fetch request pulse
	input wire logic [WAIT_WIDTH-1:0] waitCount, // programmed wait states
	output logic fetchReady // fetch completes this cycle
);
	initial begin
		if (WAIT_WIDTH < 1 || WAIT_WIDTH > 8) $error("caprf_wait_timer: bad WAIT_WIDTH");
	end

	typedef struct packed {
		caprf_fetch_e state;
		logic [WAIT_WIDTH-1:0] count;
		logic ready;
	} caprf_wait_s;

	caprf_wait_s cur_r;
	caprf_wait_s cur_nxt;

	// n programmed states stretch each fetch by exactly n cycles
	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.ready = 1'b0;
		unique case (cur_r.state)
			CAPRF_FETCH_IDLE: begin
				if (fetchReq) begin
					if (waitCount == '0) begin
						cur_nxt.ready = 1'b1;
					end else begin
						cur_nxt.count = waitCount - 1'b1;
						cur_nxt.state = CAPRF_FETCH_WAIT;
					end
				end
			end
			CAPRF_FETCH_WAIT: begin
				if (cur_r.count == '0) begin
					cur_nxt.ready = 1'b1;
					cur_nxt.state = CAPRF_FETCH_IDLE;
				end else begin
					cur_nxt.count = cur_r.count - 1'b1;
				end
			end
			// stray codes fall back to idle rather than hang a fetch
			default: begin
				cur_nxt.state = CAPRF_FETCH_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cur_r <= '{state: CAPRF_FETCH_IDLE, count: '0, ready: 1'b0};
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign fetchReady = cur_r.ready;

	// a fetch completes programmed count plus one cycles after its request
	a_wait_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cur_r.state == CAPRF_FETCH_IDLE && fetchReq && waitCount == '0) |=> fetchReady)
		else $error("zero wait fetch not ready next cycle");
	a_wait_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cur_r.state == CAPRF_FETCH_IDLE && fetchReq && waitCount == 4'd2) |=> !fetchReady ##1 !fetchReady ##1 fetchReady)
		else $error("two wait fetch timing wrong");
endmodule : caprf_wait_timer

// ==== design/caprf_regs.sv ====
// addressing and pointer special-function registers of the cpu core
// Operation
// - wait field inserts n fetch cycles
// - wait register resets to seven
// - protected registers change only under timed access
// - push writes sp+1, pop reads sp
// - wide mode stack is upper:lower pointer
// - status bits show interrupt priority in service
// - serial activity status bits are reserved
// - relocation register resets zero, written only under timed access
// - narrow 16-bit, wide 20-bit program address
// - mode field 00 narrow, 1x wide
// - stack flag shows extended stack use
// - vector relocate bit moves vectors
// - indirect high byte from port or register
// - upper byte only for indirect moves
// - pointer moves form 24-bit address
// - select bit chooses active pointer
// - direction bits make increment decrement
// - top byte joins arithmetic in wide mode
// - status word field layout
// - secondary operand register, bit addressable
`timescale 1ns/1ps
`include "caprf_map.svh"
module caprf_regs
	import caprf_pkg::*;
#(
	parameter int WAIT_WIDTH = 4
) (
	input wire logic core_clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [7:0] regAddr, // register address
	input wire logic [7:0] regWdata, // write data
	input wire logic regWe, // byte write strobe
	input wire logic regBitWe, // single bit write strobe
	input wire logic [2:0] regBitSel, // bit position for bit write
	input wire logic timedAccess, // timed-access window open
	output logic [7:0] regRdata, // read data
	input wire logic highPrioInService, // high priority isr active
	input wire logic lowPrioInService, // low priority isr active
	input wire logic [7:0] accumulator, // accumulator value
	input wire logic stackPush, // push operation
	input wire logic stackPop, // pop operation
	output logic [15:0] stackRamAddr, // stack ram address
	output logic [7:0] stackWdata, // data written by push
	output logic stackWe, // stack ram write
	output logic stackRe, // stack ram read
	input wire logic pointerIncrement, // increment-pointer instruction
	input wire logic pointerUsed, // pointer instruction completed
	input wire logic movxIndirect, // register-indirect external move
	input wire logic movxPointer, // pointer-based external move
	input wire logic [7:0] indirectLow, // indirect register low byte
	input wire logic [7:0] portTwo, // port two latch
	output logic [23:0] xdataAddr, // external data address
	output logic xdataValid, // external data address valid
	input wire logic [19:0] programCounter, // program counter
	output logic [19:0] programAddr, // program fetch address
	output logic [19:0] vectorBase, // interrupt vector base
	input wire logic arithWe, // arithmetic unit result strobe
	input wire logic [7:0] arithProduct, // result for secondary operand
	input wire logic [7:0] flagsIn, // flags from arithmetic unit
	output logic [7:0] secondaryOperand, // secondary operand value
	output logic [7:0] programStatus, // status word value
	input wire logic fetchReq, // program fetch request
	output logic fetchReady // program fetch complete
);
	initial begin
		if (WAIT_WIDTH != 4) $error("caprf_regs: wait field must be 4 bits");
	end

	typedef struct packed {
		caprf_byte_t stackPtr;
		caprf_byte_t stackUpper;
		caprf_byte_t ptr0Low;
		caprf_byte_t ptr0High;
		caprf_byte_t ptr0Top;
		caprf_byte_t ptr1Low;
		caprf_byte_t ptr1High;
		caprf_byte_t ptr1Top;
		caprf_byte_t ptrSelect;
		caprf_byte_t waitStates;
		caprf_byte_t addrControl;
		caprf_byte_t relocation;
		caprf_byte_t statusWord;
		caprf_byte_t indHigh;
		caprf_byte_t indUpper;
		caprf_byte_t secondary;
		caprf_byte_t rdata;
		logic [15:0] stackAddr;
		logic [7:0] stackData;
		logic stackWr;
		logic stackRd;
		logic [23:0] xAddr;
		logic xValid;
		logic [19:0] pAddr;
		logic [19:0] vBase;
	} caprf_state_s;

	caprf_state_s cur_r;
	caprf_state_s cur_nxt;

	// merge a byte or single bit write into a register
	function automatic caprf_byte_t merge(input caprf_byte_t old, input logic byteWr, input logic bitWr,
		input logic [2:0] pos, input caprf_byte_t data, input caprf_byte_t mask);
		caprf_byte_t v;
		v = old;
		if (byteWr) v = data;
		if (bitWr) v[pos] = data[0];
		return (v & mask) | (old & ~mask);
	endfunction : merge

	// step a 24-bit pointer; top byte held in narrow mode
	function automatic logic [23:0] stepPtr(input logic [23:0] p, input logic down, input logic wide);
		logic [23:0] r;
		r = down ? p - 24'h00_0001 : p + 24'h00_0001;
		if (!wide) r[23:16] = p[23:16];
		return r;
	endfunction : stepPtr

	logic wideMode;
	logic [15:0] stackAddrNow;
	logic [23:0] ptrActive;
	logic [7:0] readMux;
	logic selBit;

	// wait-state timing lives in its own sequencer
	caprf_wait_timer #(.WAIT_WIDTH(WAIT_WIDTH)) uWait (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.fetchReq(fetchReq),
		.waitCount(cur_r.waitStates[3:0]),
		.fetchReady(fetchReady)
	);

	// derived addressing terms
	always_comb begin
		wideMode = cur_r.addrControl[`CAPRF_BIT_ADDRESS_MODE_HI];
		stackAddrNow = wideMode ? {cur_r.stackUpper, cur_r.stackPtr} : {8'h00, cur_r.stackPtr};
		selBit = cur_r.ptrSelect[`CAPRF_BIT_SELECT];
		ptrActive = selBit ? {cur_r.ptr1Top, cur_r.ptr1High, cur_r.ptr1Low}
			: {cur_r.ptr0Top, cur_r.ptr0High, cur_r.ptr0Low};
	end

	// read decode; unmapped addresses read zero
	always_comb begin
		unique case (regAddr)
			`CAPRF_STACK_POINTER: readMux = cur_r.stackPtr;
			`CAPRF_POINTER0_LOW: readMux = cur_r.ptr0Low;
			`CAPRF_POINTER0_HIGH: readMux = cur_r.ptr0High;
			`CAPRF_POINTER1_LOW: readMux = cur_r.ptr1Low;
			`CAPRF_POINTER1_HIGH: readMux = cur_r.ptr1High;
			`CAPRF_POINTER_SELECT: readMux = cur_r.ptrSelect;
			`CAPRF_FLASH_WAIT_STATES: readMux = cur_r.waitStates;
			`CAPRF_POINTER0_TOP: readMux = cur_r.ptr0Top;
			`CAPRF_POINTER1_TOP: readMux = cur_r.ptr1Top;
			`CAPRF_STACK_POINTER_UPPER: readMux = cur_r.stackUpper;
			`CAPRF_ADDRESSING_CONTROL: readMux = cur_r.addrControl;
			// only in-service bits live here; serial activity bits stay zero
			`CAPRF_INTERRUPT_PROGRESS_STATUS: readMux = {1'b0, highPrioInService, lowPrioInService, 5'h00};
			`CAPRF_XDATA_RELOCATION: readMux = cur_r.relocation;
			`CAPRF_PROGRAM_STATUS_WORD: readMux = cur_r.statusWord;
			`CAPRF_INDIRECT_HIGH_BYTE: readMux = cur_r.indHigh;
			`CAPRF_INDIRECT_UPPER_BYTE: readMux = cur_r.indUpper;
			`CAPRF_SECONDARY_OPERAND: readMux = cur_r.secondary;
			default: readMux = 8'h00;
		endcase
	end

	// next state of every register
	always_comb begin
		logic ta;
		logic [23:0] p0;
		logic [23:0] p1;
		logic [7:0] sel;
		ta = timedAccess;
		p0 = {cur_r.ptr0Top, cur_r.ptr0High, cur_r.ptr0Low};
		p1 = {cur_r.ptr1Top, cur_r.ptr1High, cur_r.ptr1Low};
		sel = 8'h00;
		cur_nxt = cur_r;
		cur_nxt.rdata = readMux;
		cur_nxt.stackPtr = merge(cur_r.stackPtr, regWe && regAddr == `CAPRF_STACK_POINTER,
			regBitWe && regAddr == `CAPRF_STACK_POINTER, regBitSel, regWdata, 8'hff);
		cur_nxt.stackUpper = merge(cur_r.stackUpper, regWe && regAddr == `CAPRF_STACK_POINTER_UPPER,
			1'b0, regBitSel, regWdata, 8'hff);
		cur_nxt.ptr0Low = merge(cur_r.ptr0Low, regWe && regAddr == `CAPRF_POINTER0_LOW, 1'b0, regBitSel, regWdata, 8'hff);
		cur_nxt.ptr0High = merge(cur_r.ptr0High, regWe && regAddr == `CAPRF_POINTER0_HIGH, 1'b0, regBitSel, regWdata, 8'hff);
		cur_nxt.ptr0Top = merge(cur_r.ptr0Top, regWe && regAddr == `CAPRF_POINTER0_TOP, 1'b0, regBitSel, regWdata, 8'hff);
		cur_nxt.ptr1Low = merge(cur_r.ptr1Low, regWe && regAddr == `CAPRF_POINTER1_LOW, 1'b0, regBitSel, regWdata, 8'hff);
		cur_nxt.ptr1High = merge(cur_r.ptr1High, regWe && regAddr == `CAPRF_POINTER1_HIGH, 1'b0, regBitSel, regWdata, 8'hff);
		cur_nxt.ptr1Top = merge(cur_r.ptr1Top, regWe && regAddr == `CAPRF_POINTER1_TOP, 1'b0, regBitSel, regWdata, 8'hff);
		cur_nxt.ptrSelect = merge(cur_r.ptrSelect, regWe && regAddr == `CAPRF_POINTER_SELECT, 1'b0, regBitSel,
			regWdata, `CAPRF_SELECT_MASK);
		// protected registers ignore writes outside the timed-access window
		cur_nxt.waitStates = merge(cur_r.waitStates, ta && regWe && regAddr == `CAPRF_FLASH_WAIT_STATES,
			1'b0, regBitSel, regWdata, `CAPRF_WAIT_MASK);
		cur_nxt.relocation = merge(cur_r.relocation, ta && regWe && regAddr == `CAPRF_XDATA_RELOCATION,
			1'b0, regBitSel, regWdata, 8'hff);
		cur_nxt.addrControl = merge(cur_r.addrControl, ta && regWe && regAddr == `CAPRF_ADDRESSING_CONTROL,
			1'b0, regBitSel, regWdata, `CAPRF_ADDRESSING_CONTROL_MASK);
		// stack flag is read-only and mirrors the mode
		cur_nxt.addrControl[`CAPRF_BIT_STACK_EXTENDED_FLAG] = cur_nxt.addrControl[`CAPRF_BIT_ADDRESS_MODE_HI];
		cur_nxt.indHigh = merge(cur_r.indHigh, regWe && regAddr == `CAPRF_INDIRECT_HIGH_BYTE, 1'b0, regBitSel, regWdata, 8'hff);
		cur_nxt.indUpper = merge(cur_r.indUpper, regWe && regAddr == `CAPRF_INDIRECT_UPPER_BYTE, 1'b0, regBitSel,
			regWdata, 8'hff);
		// status word and secondary operand are bit addressable
		cur_nxt.statusWord = arithWe ? flagsIn : cur_r.statusWord;
		cur_nxt.statusWord = merge(cur_nxt.statusWord, regWe && regAddr == `CAPRF_PROGRAM_STATUS_WORD,
			regBitWe && regAddr == `CAPRF_PROGRAM_STATUS_WORD, regBitSel, regWdata, 8'hff);
		cur_nxt.secondary = arithWe ? arithProduct : cur_r.secondary;
		cur_nxt.secondary = merge(cur_nxt.secondary, regWe && regAddr == `CAPRF_SECONDARY_OPERAND,
			regBitWe && regAddr == `CAPRF_SECONDARY_OPERAND, regBitSel, regWdata, 8'hff);
		// push pre-increments, pop reads at the pointer then decrements
		cur_nxt.stackWr = 1'b0;
		cur_nxt.stackRd = 1'b0;
		if (stackPush) begin
			// narrow stack address wraps inside the 256-byte internal ram
			cur_nxt.stackAddr = wideMode ? stackAddrNow + 16'h0001
				: {8'h00, cur_r.stackPtr + 8'h01};
			cur_nxt.stackData = accumulator;
			cur_nxt.stackWr = 1'b1;
			{cur_nxt.stackUpper, cur_nxt.stackPtr} = wideMode ? stackAddrNow + 16'h0001
				: {cur_r.stackUpper, cur_r.stackPtr + 8'h01};
		end else if (stackPop) begin
			cur_nxt.stackAddr = stackAddrNow;
			cur_nxt.stackRd = 1'b1;
			{cur_nxt.stackUpper, cur_nxt.stackPtr} = wideMode ? stackAddrNow - 16'h0001
				: {cur_r.stackUpper, cur_r.stackPtr - 8'h01};
		end
		// pointer arithmetic on the active pointer only
		if (pointerIncrement) begin
			if (selBit) begin
				{cur_nxt.ptr1Top, cur_nxt.ptr1High, cur_nxt.ptr1Low} =
					stepPtr(p1, cur_r.ptrSelect[`CAPRF_BIT_POINTER1_DIRECTION], wideMode);
			end else begin
				{cur_nxt.ptr0Top, cur_nxt.ptr0High, cur_nxt.ptr0Low} =
					stepPtr(p0, cur_r.ptrSelect[`CAPRF_BIT_POINTER0_DIRECTION], wideMode);
			end
		end
		sel = cur_nxt.ptrSelect;
		if (pointerUsed && cur_r.ptrSelect[`CAPRF_BIT_TOGGLE_SELECT]) begin
			sel[`CAPRF_BIT_SELECT] = ~cur_r.ptrSelect[`CAPRF_BIT_SELECT];
		end
		cur_nxt.ptrSelect = sel;
		// external data address forming
		cur_nxt.xValid = movxIndirect || movxPointer;
		if (movxPointer) begin
			cur_nxt.xAddr = ptrActive;
		end else if (movxIndirect) begin
			cur_nxt.xAddr = {cur_r.indUpper,
				cur_r.addrControl[`CAPRF_BIT_ALT_HIGH_BYTE_ENABLE] ? cur_r.indHigh : portTwo, indirectLow};
		end
		// program addresses are 16 bits wide in narrow mode
		cur_nxt.pAddr = wideMode ? programCounter : {4'h0, programCounter[15:0]};
		cur_nxt.vBase = cur_r.addrControl[`CAPRF_BIT_VECTOR_RELOCATE] ? `CAPRF_VECTOR_BASE_RELOCATED
			: `CAPRF_VECTOR_BASE_NORMAL;
	end

	// all registers reset synchronously to documented values
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cur_r <= '0;
			cur_r.waitStates <= `CAPRF_WAIT_RESET;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign regRdata = cur_r.rdata;
	assign stackRamAddr = cur_r.stackAddr;
	assign stackWdata = cur_r.stackData;
	assign stackWe = cur_r.stackWr;
	assign stackRe = cur_r.stackRd;
	assign xdataAddr = cur_r.xAddr;
	assign xdataValid = cur_r.xValid;
	assign programAddr = cur_r.pAddr;
	assign vectorBase = cur_r.vBase;
	assign secondaryOperand = cur_r.secondary;
	assign programStatus = cur_r.statusWord;

	// protection, reset values and masked bits
	a_protect_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
		(regWe && !timedAccess && regAddr == `CAPRF_FLASH_WAIT_STATES) |=> $stable(cur_r.waitStates))
		else $error("unprotected write changed wait states");
	a_protect_reloc: assert property (@(posedge core_clk) disable iff (!rst_n)
		(regWe && !timedAccess && regAddr == `CAPRF_XDATA_RELOCATION) |=> $stable(cur_r.relocation))
		else $error("unprotected write changed relocation");
	a_protect_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
		(regWe && !timedAccess && regAddr == `CAPRF_ADDRESSING_CONTROL) |=> $stable(cur_r.addrControl))
		else $error("unprotected write changed addressing control");
	a_wait_reset: assert property (@(posedge core_clk) $fell(rst_n) |=> cur_r.waitStates == 8'h07)
		else $error("wait states not seven after reset");
	a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		cur_r.waitStates[7:4] == 4'h0 && cur_r.ptrSelect[4:1] == 4'h0 && cur_r.addrControl[7:6] == 2'b00
		&& !cur_r.addrControl[4])
		else $error("reserved bit set");
	// stack addressing in both modes
	a_push_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
		(stackPush && !wideMode) |=> stackWe && stackRamAddr == {8'h00, $past(cur_r.stackPtr) + 8'h01})
		else $error("push address wrong");
	a_push_data: assert property (@(posedge core_clk) disable iff (!rst_n)
		stackPush |=> stackWdata == $past(accumulator))
		else $error("push data wrong");
	a_pop_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
		(stackPop && !stackPush && !wideMode) |=> stackRe && stackRamAddr == {8'h00, $past(cur_r.stackPtr)})
		else $error("pop address wrong");
	a_wide_push: assert property (@(posedge core_clk) disable iff (!rst_n)
		(stackPush && wideMode) |=> stackWe
		&& stackRamAddr - 16'h0001 == {$past(cur_r.stackUpper), $past(cur_r.stackPtr)})
		else $error("wide push address wrong");
	// read-only status and program addressing
	a_status_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
		(regAddr == `CAPRF_INTERRUPT_PROGRESS_STATUS) |=> regRdata[4:0] == 5'h00 && regRdata[7] == 1'b0)
		else $error("reserved status bits nonzero");
	a_prio_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
		(regAddr == `CAPRF_INTERRUPT_PROGRESS_STATUS) |=> regRdata[6] == $past(highPrioInService)
		&& regRdata[5] == $past(lowPrioInService))
		else $error("in-service bits wrong");
	a_narrow_program: assert property (@(posedge core_clk) disable iff (!rst_n)
		!wideMode |=> programAddr == {4'h0, $past(programCounter[15:0])})
		else $error("narrow program address wrong");
	a_wide_program: assert property (@(posedge core_clk) disable iff (!rst_n)
		wideMode |=> programAddr == $past(programCounter))
		else $error("wide program address wrong");
	a_vector_base: assert property (@(posedge core_clk) disable iff (!rst_n)
		1'b1 |=> vectorBase == ($past(cur_r.addrControl[`CAPRF_BIT_VECTOR_RELOCATE]) ? 20'h0_b000 : 20'h0_0000))
		else $error("vector base wrong");
	// external data addresses and pointer control
	a_indirect_high: assert property (@(posedge core_clk) disable iff (!rst_n)
		(movxIndirect && !movxPointer) |=> xdataAddr[23:16] == $past(cur_r.indUpper)
		&& xdataAddr[15:8] == ($past(cur_r.addrControl[3]) ? $past(cur_r.indHigh) : $past(portTwo)))
		else $error("indirect address wrong");
	a_pointer_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
		movxPointer |=> xdataAddr == $past(ptrActive))
		else $error("pointer address wrong");
	a_select_first: assert property (@(posedge core_clk) disable iff (!rst_n)
		(movxPointer && !selBit) |=> xdataAddr == {$past(cur_r.ptr0Top), $past(cur_r.ptr0High), $past(cur_r.ptr0Low)})
		else $error("first pointer not used");
	a_select_second: assert property (@(posedge core_clk) disable iff (!rst_n)
		(movxPointer && selBit) |=> xdataAddr == {$past(cur_r.ptr1Top), $past(cur_r.ptr1High), $past(cur_r.ptr1Low)})
		else $error("second pointer not used");
	a_narrow_top: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pointerIncrement && !wideMode && !regWe) |=> $stable(cur_r.ptr0Top) && $stable(cur_r.ptr1Top))
		else $error("top byte moved in narrow mode");
	a_toggle_select: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pointerUsed && cur_r.ptrSelect[5] && !regWe) |=> selBit != $past(selBit))
		else $error("select did not toggle");
	a_stack_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		cur_r.addrControl[2] == cur_r.addrControl[1])
		else $error("stack flag mismatch");
endmodule : caprf_regs

// ==== testbench/tb_top.sv ====
// self-checking bench for the addressing and pointer register block
`timescale 1ns/1ps
`include "caprf_map.svh"
module tb_top import caprf_pkg::*; ;
	typedef struct {logic [7:0] a; logic [7:0] d; logic ta; logic [7:0] e;} caprf_row_s;
	logic core_clk = 0, rst_n = 0, regWe = 0, regBitWe = 0, timedAccess = 0;
	logic highPrioInService = 0, lowPrioInService = 0, stackPush = 0, stackPop = 0;
	logic pointerIncrement = 0, pointerUsed = 0, movxIndirect = 0, movxPointer = 0, arithWe = 0, fetchReq = 0;
	logic [7:0] regAddr = 0, regWdata = 0, accumulator = 0, indirectLow = 0, portTwo = 0;
	logic [7:0] arithProduct = 0, flagsIn = 0, regRdata, stackWdata, secondaryOperand, programStatus;
	logic [2:0] regBitSel = 0;
	logic [19:0] programCounter = 0, programAddr, vectorBase;
	logic [15:0] stackRamAddr;
	logic [23:0] xdataAddr;
	logic stackWe, stackRe, xdataValid, fetchReady;
	int n_fail = 0, samples_checked = 0;
	logic [7:0] regList [17] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h92, 8'h93, 8'h95, 8'h9b, 8'h9d,
		8'hc5, 8'hc6, 8'hd0, 8'hda, 8'hea, 8'hf0};
	// write, then read back; protected rows mix writes with and without timed access
	caprf_row_s rows [14] = '{'{8'h92, 8'hff, 0, 8'h07}, '{8'h92, 8'hff, 1, 8'h0f}, '{8'h92, 8'h03, 1, 8'h03},
		'{8'hc6, 8'h01, 0, 8'h00}, '{8'hc6, 8'h01, 1, 8'h01}, '{8'hc6, 8'h00, 1, 8'h00},
		'{8'h9d, 8'hff, 0, 8'h00}, '{8'h86, 8'hff, 0, 8'he1}, '{8'hc5, 8'hff, 1, 8'h00},
		'{8'hd0, 8'ha5, 0, 8'ha5}, '{8'hf0, 8'h5a, 0, 8'h5a}, '{8'h95, 8'h3c, 0, 8'h3c},
		'{8'hea, 8'hc3, 0, 8'hc3}, '{8'h80, 8'hff, 1, 8'h00}};

	caprf_regs #(.WAIT_WIDTH(4)) u_caprf_regs (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWe(regWe), .regBitWe(regBitWe), .regBitSel(regBitSel), .timedAccess(timedAccess),
		.regRdata(regRdata), .highPrioInService(highPrioInService), .lowPrioInService(lowPrioInService),
		.accumulator(accumulator), .stackPush(stackPush), .stackPop(stackPop), .stackRamAddr(stackRamAddr),
		.stackWdata(stackWdata), .stackWe(stackWe), .stackRe(stackRe), .pointerIncrement(pointerIncrement),
		.pointerUsed(pointerUsed), .movxIndirect(movxIndirect), .movxPointer(movxPointer),
		.indirectLow(indirectLow), .portTwo(portTwo), .xdataAddr(xdataAddr), .xdataValid(xdataValid),
		.programCounter(programCounter), .programAddr(programAddr), .vectorBase(vectorBase), .arithWe(arithWe),
		.arithProduct(arithProduct), .flagsIn(flagsIn), .secondaryOperand(secondaryOperand),
		.programStatus(programStatus), .fetchReq(fetchReq), .fetchReady(fetchReady));

	// 100 MHz clock
	always #5 core_clk = ~core_clk;

	// wide enough for the longest grouped compare, so no field is cut off
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// all drives land on the falling edge, away from the sampling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ta);
		@(negedge core_clk);
		regAddr = a;
		regWdata = d;
		regWe = 1;
		timedAccess = ta;
		@(negedge core_clk);
		regWe = 0;
		timedAccess = 0;
	endtask : wr

	// read data is registered, so it is settled one falling edge later
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		regAddr = a;
		@(negedge core_clk);
		check(regRdata, exp);
	endtask : rc

	task automatic pulse(ref logic s);
		@(negedge core_clk);
		s = 1;
		@(negedge core_clk);
		s = 0;
	endtask : pulse

	// counts cycles from the request to the completion pulse
	task automatic fetch(input int n);
		int k;
		k = 0;
		@(negedge core_clk);
		fetchReq = 1;
		repeat (20) begin
			@(negedge core_clk);
			fetchReq = 0;
			k++;
			if (fetchReady === 1'b1) break;
		end
		check(24'(k), 24'(n + 1));
	endtask : fetch

	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(negedge core_clk);
		rst_n = 1;
		foreach (regList[i]) rc(regList[i], (regList[i] == 8'h92) ? 8'h07 : 8'h00);
		fetch(7);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].ta);
			rc(rows[i].a, rows[i].e);
		end
		fetch(3);
		wr(8'h92, 8'h02, 1);
		fetch(2);
		wr(8'h92, 8'h00, 1);
		fetch(0);
		wr(8'h92, 8'h0f, 1);
		fetch(15);
		for (int i = 0; i < 4; i++) begin
			{highPrioInService, lowPrioInService} = 2'(i);
			rc(8'hc5, {1'b0, 2'(i), 5'b0_0000});
		end
		// narrow stack wraps inside the 256-byte internal ram
		wr(8'h81, 8'hff, 0);
		accumulator = 8'h3c;
		pulse(stackPush);
		check({stackWe, stackWdata, stackRamAddr}, {1'b1, 8'h3c, 16'h0000});
		pulse(stackPop);
		check({stackRe, stackRamAddr}, {1'b1, 16'h0000});
		rc(8'h81, 8'hff);
		programCounter = 20'ha_bcde;
		@(negedge core_clk);
		check({programAddr, vectorBase}, {20'h0_bcde, 20'h0_0000});
		// wide mode with relocated vectors
		wr(8'h9b, 8'h12, 0);
		wr(8'h81, 8'h34, 0);
		wr(8'h9d, 8'h22, 1);
		rc(8'h9d, 8'h26);
		check({programAddr, vectorBase}, {20'ha_bcde, 20'h0_b000});
		pulse(stackPush);
		check({stackWe, stackRamAddr}, {1'b1, 16'h1235});
		// wide pointer arithmetic carries into the top byte
		wr(8'h86, 8'h00, 0);
		wr(8'h93, 8'h55, 0);
		wr(8'h82, 8'hff, 0);
		wr(8'h83, 8'hff, 0);
		pulse(pointerIncrement);
		rc(8'h93, 8'h56);
		pulse(movxPointer);
		check({xdataValid, xdataAddr}, {1'b1, 24'h56_0000});
		wr(8'h9d, 8'h00, 1);
		wr(8'h86, 8'h40, 0);
		pulse(pointerIncrement);
		rc(8'h83, 8'hff);
		rc(8'h93, 8'h56);
		wr(8'h86, 8'h81, 0);
		pulse(pointerIncrement);
		rc(8'h84, 8'hff);
		pulse(movxPointer);
		check({xdataValid, xdataAddr}, {1'b1, 24'h3c_ffff});
		wr(8'h86, 8'h21, 0);
		pulse(pointerUsed);
		rc(8'h86, 8'h20);
		// indirect moves take the middle byte from the port, then from the register
		wr(8'hda, 8'h44, 0);
		portTwo = 8'h11;
		indirectLow = 8'h22;
		pulse(movxIndirect);
		check({xdataValid, xdataAddr}, {1'b1, 24'hc3_1122});
		wr(8'h9d, 8'h08, 1);
		pulse(movxIndirect);
		check(xdataAddr, 24'hc3_4422);
		flagsIn = 8'hc3;
		arithProduct = 8'h5a;
		pulse(arithWe);
		check({programStatus, secondaryOperand}, {8'hc3, 8'h5a});
		regAddr = 8'hf0;
		regBitSel = 3'd7;
		regWdata = 8'h01;
		pulse(regBitWe);
		check(secondaryOperand, 8'hda);
		// second reset in mid-run
		rst_n = 0;
		repeat (2) @(negedge core_clk);
		rst_n = 1;
		rc(8'h92, 8'h07);
		rc(8'h9d, 8'h00);
		tally_and_finish();
	end
endmodule : tb_top
